// ==== design/ubc_map.svh ====
// register indices, field positions and link codes of the break and trace unit
`ifndef UBC_MAP_SVH
`define UBC_MAP_SVH
// device register indices on the configuration port
`define IDX_BAR_A 4'h0
`define IDX_MASK_A 4'h1
`define IDX_COND_A 4'h2
`define IDX_BAR_B 4'h3
`define IDX_MASK_B 4'h4
`define IDX_COND_B 4'h5
`define IDX_DATA_B 4'h6
`define IDX_DMASK_B 4'h7
`define IDX_CTRL 4'h8
`define IDX_EXEC_CNT 4'h9
`define CFG_REGS 10
// bus cycle condition fields, two bits each
`define CF_BUS 0
`define CF_KIND 2
`define CF_DIR 4
`define CF_SIZE 6
// break control bits
`define CT_SEQ 0
`define CT_TRACE_ENABLE_BIT 1
`define CT_CNT_EN 2
`define CT_POST_A 3
`define CT_POST_B 4
`define CT_DATA_EN 5
// trace entries
`define ENT_VALID 31
`define ENT_PTR 28
`define ENT_ADDR_W 28
`define PTR_INVALID 3'h7
`define TRACE_DEPTH 8
// trace read selects
`define RD_SRC 2'h0
`define RD_DST 2'h1
`define RD_STAT 2'h2
// apb offsets of the controller
`define HA_CFG_DATA 12'h000
`define HA_CFG_CMD 12'h004
`define HA_TRACE 12'h008
`define HA_SRC 12'h00C
`define HA_DST 12'h010
`define HA_STAT 12'h014
`define HA_SPC 12'h018
`endif

// ==== design/ubc_pkg.sv ====
// types shared by both ends of the break and trace link
package ubc_pkg;
  typedef enum logic [1:0] {SZ_NONE, SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;
  typedef enum logic [2:0] {BK_NONE, BK_FETCH_PRE, BK_FETCH_POST, BK_DATA_ADDR,
    BK_DATA_VAL} brk_kind_t;
  typedef enum {HS_IDLE, HS_SRC, HS_DST} host_state_t;
endpackage

// ==== design/ubc_link_if.sv ====
// link between the cpu side controller and the break and trace unit
`timescale 1ns/1ps
interface ubc_link_if;
  import ubc_pkg::*;
  // configuration writes
  logic cfg_we;
  logic [3:0] cfg_idx;
  logic [31:0] cfg_wdata;
  // trace reads
  logic rd_req;
  logic [1:0] rd_sel;
  logic rd_long;
  logic rd_ack;
  logic [31:0] rd_data;
  // monitored bus cycle
  logic bc_valid;
  logic [31:0] bc_addr;
  logic [31:0] bc_data;
  op_size_t bc_size;
  logic bc_write;
  logic bc_dma;
  logic bc_fetch;
  logic [31:0] bc_pc;
  logic [31:0] bc_next_pc;
  // branch events
  logic tr_valid;
  logic tr_intr;
  logic [27:0] tr_ia;
  logic [27:0] tr_fetch;
  logic [27:0] tr_dst;
  logic tr_dslot;
  logic [27:0] tr_pend;
  logic tr_exec;
  // break answer
  logic brk_req;
  brk_kind_t brk_kind;
  logic [31:0] brk_spc;
  modport dev (input cfg_we, cfg_idx, cfg_wdata, rd_req, rd_sel, rd_long, bc_valid,
    bc_addr, bc_data, bc_size, bc_write, bc_dma, bc_fetch, bc_pc, bc_next_pc, tr_valid,
    tr_intr, tr_ia, tr_fetch, tr_dst, tr_dslot, tr_pend, tr_exec,
    output rd_ack, rd_data, brk_req, brk_kind, brk_spc);
  modport host (output cfg_we, cfg_idx, cfg_wdata, rd_req, rd_sel, rd_long, bc_valid,
    bc_addr, bc_data, bc_size, bc_write, bc_dma, bc_fetch, bc_pc, bc_next_pc, tr_valid,
    tr_intr, tr_ia, tr_fetch, tr_dst, tr_dslot, tr_pend, tr_exec,
    input rd_ack, rd_data, brk_req, brk_kind, brk_spc);
endinterface

// ==== design/chan_match.sv ====
// one break channel: bus cycle, address and optional data comparison
`timescale 1ns/1ps
`include "ubc_map.svh"
module chan_match #(
  parameter bit USE_DATA = 1'b0
) (
  // channel setup
  input wire logic [31:0] brk_addr,
  input wire logic [31:0] brk_mask,
  input wire logic [7:0] cond,
  input wire logic data_en,
  input wire logic [31:0] brk_data,
  input wire logic [31:0] data_mask,
  // bus cycle
  input wire logic bc_valid,
  input wire logic [31:0] bc_addr,
  input wire logic [31:0] bc_data,
  input wire ubc_pkg::op_size_t bc_size,
  input wire logic bc_write,
  input wire logic bc_dma,
  input wire logic bc_fetch,
  // result
  output logic hit
);
  import ubc_pkg::*;
  wire [1:0] bus_sel = cond[`CF_BUS+:2];
  wire [1:0] kind_sel = cond[`CF_KIND+:2];
  wire [1:0] dir_sel = cond[`CF_DIR+:2];
  wire [1:0] size_sel = cond[`CF_SIZE+:2];
  // a bus, kind or direction group left at 00 never matches
  wire grp_ok = (bc_dma ? bus_sel[1] : bus_sel[0]) && (bc_fetch ? kind_sel[0] : kind_sel[1])
    && (bc_write ? dir_sel[1] : dir_sel[0]);
  wire size_ok = (size_sel == 2'h0) || (size_sel == 2'(bc_size));
  // low address bits below the access size take no part
  wire [31:0] keep = (bc_size == SZ_LONG) ? 32'hFFFFFFFC :
    (bc_size == SZ_WORD) ? 32'hFFFFFFFE : 32'hFFFFFFFF;
  wire addr_ok = ((brk_addr ^ bc_addr) & ~brk_mask & keep) == 32'h0;
  // upper half ignored for word and byte; byte compares the low lane only
  wire [31:0] width = (bc_size == SZ_LONG) ? 32'hFFFFFFFF :
    (bc_size == SZ_WORD) ? 32'h0000FFFF : 32'h000000FF;
  wire use_data = USE_DATA && data_en && !bc_fetch;
  wire data_ok = !use_data || (((brk_data ^ bc_data) & ~data_mask & width) == 32'h0);
  // address and data must agree in the same bus cycle
  assign hit = bc_valid && grp_ok && size_ok && addr_ok && data_ok;
endmodule

// ==== design/break_unit.sv ====
// break matching, saved pc selection and branch trace queue of the device
// Overview of operation
// - address compare width follows access size
// - data break needs address and data match
// - software duplicates byte data in both bytes
// - word or byte ignores upper data half
// - software gives operand size with data break
// - dma breaks use byte, word or none
// - sequence mode: b breaks only after a
// - b before a is ignored
// - simultaneous a and b in sequence mode gives no break
// - execution count gates channel b break
// - pre-fetch break saves matching instruction address
// - post-fetch break saves next instruction address
// - address data break saves following address
// - value data break may be imprecise
// - trace records source and destination per branch
// - source address minus twice pointer gives origin
// - pending 4n+2 destination stored, pointer invalid
// - interrupt source last instruction, destination vector
// - eight pairs, shared read pointer, advance on destination
// - read source first, destination by longword
// - trace pointer bottom start, pushed up, steps down
// - trace re-enable invalidates queue, keeps read pointer
// - destination valid set on capture, cleared on read
`timescale 1ns/1ps
`include "ubc_map.svh"
module break_unit #(
  parameter int DEPTH = `TRACE_DEPTH
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // link to the cpu side
  ubc_link_if.dev LNK,
  // towards the interrupt controller
  output logic BRK_IRQ,
  output logic MATCH_A,
  output logic MATCH_B
);
  import ubc_pkg::*;
  localparam int PW = $clog2(DEPTH) + 1;

  // configuration store and outputs
  logic [31:0] cfg_reg [0:`CFG_REGS-1];
  logic a_seen_reg;
  logic [15:0] cnt_reg;
  logic brk_reg;
  brk_kind_t kind_reg;
  logic [31:0] spc_reg;
  logic match_a_reg;
  logic match_b_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  // trace queue
  logic [31:0] src_q [0:DEPTH-1];
  logic [31:0] dst_q [0:DEPTH-1];
  logic [PW-1:0] rp_reg;
  logic [PW-1:0] tp_reg;
  logic trace_enable_bit_d_reg;

  // saturating step of a queue pointer
  function automatic logic [PW-1:0] step(input logic [PW-1:0] v, input logic up,
    input logic dn, input logic [PW-1:0] lim);
    logic [PW-1:0] r;
    r = v;
    if (up && !dn && v < lim)
      r = v + PW'(1);
    else if (dn && !up && v != '0)
      r = v - PW'(1);
    return r;
  endfunction

  wire [31:0] ctrl = cfg_reg[`IDX_CTRL];
  wire seq = ctrl[`CT_SEQ];
  wire trace_enable_bit = ctrl[`CT_TRACE_ENABLE_BIT];
  wire hit_a;
  wire hit_b;

  chan_match #(.USE_DATA(1'b0)) u_match_a (
    .brk_addr(cfg_reg[`IDX_BAR_A]),
    .brk_mask(cfg_reg[`IDX_MASK_A]),
    .cond(cfg_reg[`IDX_COND_A][7:0]),
    .data_en(1'b0),
    .brk_data(32'h00000000),
    .data_mask(32'hFFFFFFFF),
    .bc_valid(LNK.bc_valid),
    .bc_addr(LNK.bc_addr),
    .bc_data(LNK.bc_data),
    .bc_size(LNK.bc_size),
    .bc_write(LNK.bc_write),
    .bc_dma(LNK.bc_dma),
    .bc_fetch(LNK.bc_fetch),
    .hit(hit_a)
  );

  chan_match #(.USE_DATA(1'b1)) u_match_b (
    .brk_addr(cfg_reg[`IDX_BAR_B]),
    .brk_mask(cfg_reg[`IDX_MASK_B]),
    .cond(cfg_reg[`IDX_COND_B][7:0]),
    .data_en(ctrl[`CT_DATA_EN]),
    .brk_data(cfg_reg[`IDX_DATA_B]),
    .data_mask(cfg_reg[`IDX_DMASK_B]),
    .bc_valid(LNK.bc_valid),
    .bc_addr(LNK.bc_addr),
    .bc_data(LNK.bc_data),
    .bc_size(LNK.bc_size),
    .bc_write(LNK.bc_write),
    .bc_dma(LNK.bc_dma),
    .bc_fetch(LNK.bc_fetch),
    .hit(hit_b)
  );

  // sequence qualification: b counts only after an earlier a, never together
  wire b_qual = hit_b && (!seq || (a_seen_reg && !hit_a));
  wire [15:0] cnt_inc = cnt_reg + 16'h0001;
  wire cnt_done = !ctrl[`CT_CNT_EN] || (cnt_inc >= cfg_reg[`IDX_EXEC_CNT][15:0]);
  wire b_break = b_qual && cnt_done;
  wire a_break = hit_a && !seq;
  wire brk = a_break || b_break;
  // kind of break decides which pc is saved
  wire post_ch = a_break ? ctrl[`CT_POST_A] : ctrl[`CT_POST_B];
  wire val_brk = !a_break && ctrl[`CT_DATA_EN];
  wire brk_kind_t kind_now = LNK.bc_fetch ? (post_ch ? BK_FETCH_POST : BK_FETCH_PRE) :
    (val_brk ? BK_DATA_VAL : BK_DATA_ADDR);
  // pre-fetch keeps the matched instruction; all others resume after it
  wire [31:0] spc_now = (kind_now == BK_FETCH_PRE) ? LNK.bc_pc : LNK.bc_next_pc;

  // sequence state, execution counter and break outputs
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      a_seen_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      brk_reg <= 1'b0;
      kind_reg <= BK_NONE;
      spc_reg <= 32'h00000000;
      match_a_reg <= 1'b0;
      match_b_reg <= 1'b0;
    end
    else
    begin
      // a new a match wins over the clear taken by a break
      if (seq && hit_a)
        a_seen_reg <= 1'b1;
      else if (b_break || !seq)
        a_seen_reg <= 1'b0;
      if (b_break)
        cnt_reg <= 16'h0000;
      else if (b_qual)
        cnt_reg <= cnt_inc;
      brk_reg <= brk;
      match_a_reg <= hit_a;
      match_b_reg <= hit_b;
      if (brk)
      begin
        kind_reg <= kind_now;
        spc_reg <= spc_now;
      end
    end
  end

  // trace source entry: origin pointer such that origin = address - 2 * pointer
  wire [27:0] ptr_diff = LNK.tr_fetch - LNK.tr_ia;
  wire pend_case = LNK.tr_intr && LNK.tr_dslot && (LNK.tr_pend[1:0] == 2'b10);
  wire [31:0] src_new = pend_case ? {1'b1, `PTR_INVALID, LNK.tr_pend} :
    {1'b1, ptr_diff[3:1], LNK.tr_fetch};
  wire [31:0] dst_new = {4'h8, LNK.tr_dst};
  wire push = trace_enable_bit && LNK.tr_valid;
  wire rise = trace_enable_bit && !trace_enable_bit_d_reg;
  wire pop = LNK.rd_req && LNK.rd_sel == `RD_DST && LNK.rd_long && rp_reg != '0;
  wire [PW-1:0] top = rp_reg - PW'(1);
  wire [PW-1:0] clr_idx = push ? rp_reg : top;
  wire [31:0] rd_mux = (rp_reg == '0) ? 32'h00000000 :
    (LNK.rd_sel == `RD_SRC) ? src_q[top[PW-2:0]] :
    (LNK.rd_sel == `RD_DST) ? dst_q[top[PW-2:0]] : 32'h00000000;
  wire [31:0] stat_word = {16'h0000, 8'(rp_reg), 8'(tp_reg)};

  // queue shifts up on each push; bottom is index zero
  always_ff @(posedge SYS_CLK)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (push)
      begin
        src_q[i] <= (i == 0) ? src_new : src_q[i-1];
        dst_q[i] <= (i == 0) ? dst_new : dst_q[i-1];
      end
      // stale contents after re-enable, and destination entries once read, show invalid
      if (rise)
      begin
        src_q[i][`ENT_VALID] <= 1'b0;
        dst_q[i][`ENT_VALID] <= 1'b0;
      end
      else if (pop && PW'(i) == clr_idx)
        dst_q[i][`ENT_VALID] <= 1'b0;
    end
  end

  // pointers and read answers
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rp_reg <= '0;
      tp_reg <= '0;
      trace_enable_bit_d_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      trace_enable_bit_d_reg <= trace_enable_bit;
      rp_reg <= step(rp_reg, push, pop, PW'(DEPTH));
      if (rise)
        tp_reg <= '0;
      else
        tp_reg <= step(tp_reg, push, LNK.tr_exec, PW'(DEPTH - 1));
      ack_reg <= LNK.rd_req;
      if (LNK.rd_req)
        rdata_reg <= (LNK.rd_sel == `RD_STAT) ? stat_word : rd_mux;
    end
  end

  // configuration writes; contents cleared at reset for a defined start
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < `CFG_REGS; i++)
        cfg_reg[i] <= 32'h00000000;
    end
    else if (LNK.cfg_we && LNK.cfg_idx < 4'(`CFG_REGS))
      cfg_reg[LNK.cfg_idx] <= LNK.cfg_wdata;
  end

  assign LNK.rd_ack = ack_reg;
  assign LNK.rd_data = rdata_reg;
  assign LNK.brk_req = brk_reg;
  assign LNK.brk_kind = kind_reg;
  assign LNK.brk_spc = spc_reg;
  assign BRK_IRQ = brk_reg;
  assign MATCH_A = match_a_reg;
  assign MATCH_B = match_b_reg;
endmodule

// ==== design/break_host.sv ====
// cpu side controller: apb registers, setup checks, trace reads, bus cycle feed
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "ubc_map.svh"
module break_host (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pipeline bus cycle and branch events
  input wire logic BC_VALID,
  input wire logic [31:0] BC_ADDR,
  input wire logic [31:0] BC_DATA,
  input wire ubc_pkg::op_size_t BC_SIZE,
  input wire logic BC_WRITE,
  input wire logic BC_DMA,
  input wire logic BC_FETCH,
  input wire logic [31:0] BC_PC,
  input wire logic [31:0] BC_NEXT_PC,
  input wire logic TR_VALID,
  input wire logic TR_INTR,
  input wire logic [27:0] TR_IA,
  input wire logic [27:0] TR_FETCH,
  input wire logic [27:0] TR_DST,
  input wire logic TR_DSLOT,
  input wire logic [27:0] TR_PEND,
  input wire logic TR_EXEC,
  // link to the device
  ubc_link_if.host LNK
);
  import ubc_pkg::*;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic slverr_reg;
  logic [31:0] data_reg;
  logic data_en_reg;
  logic [1:0] size_b_reg;
  logic cfg_we_reg;
  logic [3:0] cfg_idx_reg;
  logic [31:0] cfg_wdata_reg;
  host_state_t state_reg;
  logic rd_req_reg;
  logic [1:0] rd_sel_reg;
  logic [31:0] src_res_reg;
  logic [31:0] dst_res_reg;
  logic [31:0] spc_reg;
  logic [2:0] kind_reg;
  logic brk_seen_reg;

  // apb decode; the completing edge is the one that sees pready high
  wire done = PSEL && PENABLE && pready_reg;
  wire wr = done && PWRITE;
  wire mapped = PADDR <= `HA_SPC && PADDR[1:0] == 2'b00;
  wire [3:0] cmd_idx = PWDATA[3:0];
  wire [1:0] cmd_size = data_reg[`CF_SIZE+:2];
  wire cmd_dma = data_reg[`CF_BUS+1];
  // a data break must carry an operand size; dma cannot use longword
  wire [1:0] size_fix = (data_en_reg && cmd_size == 2'h0) ? (cmd_dma ? 2'h2 : 2'h3) :
    (cmd_dma && cmd_size == 2'h3) ? 2'h2 : cmd_size;
  wire is_cond = cmd_idx == `IDX_COND_A || cmd_idx == `IDX_COND_B;
  wire is_dat = cmd_idx == `IDX_DATA_B || cmd_idx == `IDX_DMASK_B;
  // byte data goes into both low bytes
  wire [31:0] cmd_data = is_cond ? {data_reg[31:8], size_fix, data_reg[5:0]} :
    (is_dat && size_b_reg == 2'h1) ? {16'h0000, data_reg[7:0], data_reg[7:0]} :
    data_reg;
  wire busy = state_reg != HS_IDLE;
  wire [31:0] rd_mux = (PADDR == `HA_CFG_DATA) ? data_reg :
    (PADDR == `HA_SRC) ? src_res_reg : (PADDR == `HA_DST) ? dst_res_reg :
    (PADDR == `HA_STAT) ? {27'h0, brk_seen_reg, kind_reg, busy} :
    (PADDR == `HA_SPC) ? spc_reg : 32'h00000000;

  // apb slave: one wait state on every access
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
      data_reg <= 32'h00000000;
      data_en_reg <= 1'b0;
      size_b_reg <= 2'h0;
      cfg_we_reg <= 1'b0;
      cfg_idx_reg <= 4'h0;
      cfg_wdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= PSEL && PENABLE && !pready_reg;
      if (PSEL && PENABLE && !pready_reg)
      begin
        prdata_reg <= PWRITE ? 32'h00000000 : rd_mux;
        slverr_reg <= !mapped;
      end
      if (wr && PADDR == `HA_CFG_DATA)
        data_reg <= PWDATA;
      cfg_we_reg <= wr && PADDR == `HA_CFG_CMD;
      if (wr && PADDR == `HA_CFG_CMD)
      begin
        cfg_idx_reg <= cmd_idx;
        cfg_wdata_reg <= cmd_data;
        if (cmd_idx == `IDX_CTRL)
          data_en_reg <= data_reg[`CT_DATA_EN];
        if (cmd_idx == `IDX_COND_B)
          size_b_reg <= size_fix;
      end
    end
  end

  // trace read pair: source first, then destination as a longword
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_reg <= HS_IDLE;
      rd_req_reg <= 1'b0;
      rd_sel_reg <= `RD_SRC;
      src_res_reg <= 32'h00000000;
      dst_res_reg <= 32'h00000000;
    end
    else
    begin
      rd_req_reg <= 1'b0;
      case (state_reg)
        HS_IDLE:
          if (wr && PADDR == `HA_TRACE)
          begin
            state_reg <= HS_SRC;
            rd_req_reg <= 1'b1;
            rd_sel_reg <= PWDATA[0] ? `RD_STAT : `RD_SRC;
          end
        HS_SRC:
          if (LNK.rd_ack)
          begin
            src_res_reg <= LNK.rd_data;
            state_reg <= (rd_sel_reg == `RD_STAT) ? HS_IDLE : HS_DST;
            rd_req_reg <= rd_sel_reg != `RD_STAT;
            rd_sel_reg <= `RD_DST;
          end
        HS_DST:
          if (LNK.rd_ack)
          begin
            dst_res_reg <= LNK.rd_data;
            state_reg <= HS_IDLE;
          end
        default:
          state_reg <= HS_IDLE;
      endcase
    end
  end

  // pipeline feed and break capture
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      LNK.bc_valid <= 1'b0;
      LNK.bc_addr <= 32'h00000000;
      LNK.bc_data <= 32'h00000000;
      LNK.bc_size <= SZ_NONE;
      LNK.bc_write <= 1'b0;
      LNK.bc_dma <= 1'b0;
      LNK.bc_fetch <= 1'b0;
      LNK.bc_pc <= 32'h00000000;
      LNK.bc_next_pc <= 32'h00000000;
      LNK.tr_valid <= 1'b0;
      LNK.tr_intr <= 1'b0;
      LNK.tr_ia <= 28'h0000000;
      LNK.tr_fetch <= 28'h0000000;
      LNK.tr_dst <= 28'h0000000;
      LNK.tr_dslot <= 1'b0;
      LNK.tr_pend <= 28'h0000000;
      LNK.tr_exec <= 1'b0;
      spc_reg <= 32'h00000000;
      kind_reg <= 3'h0;
      brk_seen_reg <= 1'b0;
    end
    else
    begin
      LNK.bc_valid <= BC_VALID;
      LNK.bc_addr <= BC_ADDR;
      LNK.bc_data <= BC_DATA;
      LNK.bc_size <= BC_SIZE;
      LNK.bc_write <= BC_WRITE;
      LNK.bc_dma <= BC_DMA;
      LNK.bc_fetch <= BC_FETCH;
      LNK.bc_pc <= BC_PC;
      LNK.bc_next_pc <= BC_NEXT_PC;
      LNK.tr_valid <= TR_VALID;
      LNK.tr_intr <= TR_INTR;
      LNK.tr_ia <= TR_IA;
      LNK.tr_fetch <= TR_FETCH;
      LNK.tr_dst <= TR_DST;
      LNK.tr_dslot <= TR_DSLOT;
      LNK.tr_pend <= TR_PEND;
      LNK.tr_exec <= TR_EXEC;
      // a new break wins over the clear by reading status
      if (LNK.brk_req)
      begin
        spc_reg <= LNK.brk_spc;
        kind_reg <= 3'(LNK.brk_kind);
        brk_seen_reg <= 1'b1;
      end
      else if (done && !PWRITE && PADDR == `HA_STAT)
        brk_seen_reg <= 1'b0;
    end
  end

  assign LNK.cfg_we = cfg_we_reg;
  assign LNK.cfg_idx = cfg_idx_reg;
  assign LNK.cfg_wdata = cfg_wdata_reg;
  assign LNK.rd_req = rd_req_reg;
  assign LNK.rd_sel = rd_sel_reg;
  assign LNK.rd_long = 1'b1;
  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = slverr_reg;
endmodule

// ==== verif/ubc_link_props.sv ====
// assertions on the link between the controller and the break unit
`timescale 1ns/1ps
module ubc_link_props
  import ubc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // trace reads
  input wire logic rd_req,
  input wire logic rd_long,
  input wire logic rd_ack,
  // bus cycle and break answer
  input wire logic bc_valid,
  input wire logic bc_fetch,
  input wire logic [31:0] bc_pc,
  input wire logic [31:0] bc_next_pc,
  input wire logic brk_req,
  input wire brk_kind_t brk_kind,
  input wire logic [31:0] brk_spc
);
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);
  // a read is answered in the next cycle and only then
  ack_follows_req_a: assert property (rd_req |=> rd_ack)
    else $error("trace read not answered");
  ack_has_req_a: assert property (rd_ack |-> $past(rd_req))
    else $error("trace answer without request");
  // target entries are always read as a longword
  read_long_a: assert property (rd_req |-> rd_long)
    else $error("trace read not longword");
  // a break needs a compared bus cycle one cycle before
  break_cause_a: assert property (brk_req |-> $past(bc_valid))
    else $error("break without bus cycle");
  break_kind_a: assert property (brk_req |-> brk_kind != BK_NONE)
    else $error("break without kind");
  // saved pc per break kind, except value data breaks
  spc_pre_a: assert property (brk_req && brk_kind == BK_FETCH_PRE |-> brk_spc == $past(bc_pc))
    else $error("pre fetch saved pc wrong");
  spc_post_a: assert property (brk_req && brk_kind == BK_FETCH_POST |-> brk_spc == $past(bc_next_pc))
    else $error("post fetch saved pc wrong");
  spc_data_a: assert property (brk_req && brk_kind == BK_DATA_ADDR |-> brk_spc == $past(bc_next_pc))
    else $error("data saved pc wrong");
  data_kind_a: assert property (brk_req && !$past(bc_fetch) |-> brk_kind inside {BK_DATA_ADDR, BK_DATA_VAL})
    else $error("data break with fetch kind");
  // saved pc stands until the next break
  spc_stands_a: assert property (!brk_req |-> $stable(brk_spc))
    else $error("saved pc moved without break");
endmodule

// ==== verif/user_break_match_and_pc_trace_tb.sv ====
// self-checking bench for the break host and break unit pair
`timescale 1ns/1ps
`include "ubc_map.svh"
module user_break_match_and_pc_trace_tb;
  import ubc_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] d; op_size_t s; logic w; logic [31:0] n;} row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata, spc_seen;
  logic pready, pslverr, rerr, brk_irq;
  logic bcv = 1'b0;
  logic bcw = 1'b0;
  logic bcf = 1'b0;
  logic [31:0] bca = 32'h0;
  logic [31:0] bcd = 32'h0;
  op_size_t bcs = SZ_NONE;
  logic tr_v = 1'b0;
  logic tr_int = 1'b0;
  logic tr_ds = 1'b0;
  logic tr_ex = 1'b0;
  logic [27:0] tr_ia = 28'h0;
  logic [27:0] tr_ft = 28'h0;
  logic [27:0] tr_dt = 28'h0;
  logic [27:0] tr_pd = 28'h0;
  int n_fail = 0;
  int samples_checked = 0;
  int hits = 0;
  int cyc = 0;
  // channel a: data read at 1003, any size; channel b: word write of A512 at 2000
  row_t rows [8] = '{
    '{32'h1000, 32'h0, SZ_LONG, 1'b0, 32'h1}, '{32'h1002, 32'h0, SZ_WORD, 1'b0, 32'h1},
    '{32'h1003, 32'h0, SZ_BYTE, 1'b0, 32'h1}, '{32'h1002, 32'h0, SZ_BYTE, 1'b0, 32'h0},
    '{32'h1000, 32'h0, SZ_WORD, 1'b0, 32'h0}, '{32'h2000, 32'hA512, SZ_WORD, 1'b1, 32'h1},
    '{32'h2000, 32'hA513, SZ_WORD, 1'b1, 32'h0}, '{32'h2004, 32'hA512, SZ_WORD, 1'b1, 32'h0}};
  ubc_link_if lnk();
  break_host i_break_host (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BC_VALID(bcv), .BC_ADDR(bca), .BC_DATA(bcd), .BC_SIZE(bcs),
    .BC_WRITE(bcw), .BC_DMA(1'b0), .BC_FETCH(bcf), .BC_PC(bca), .BC_NEXT_PC(bca + 32'h2),
    .TR_VALID(tr_v), .TR_INTR(tr_int), .TR_IA(tr_ia), .TR_FETCH(tr_ft), .TR_DST(tr_dt),
    .TR_DSLOT(tr_ds), .TR_PEND(tr_pd), .TR_EXEC(tr_ex), .LNK(lnk));
  break_unit i_break_unit (.SYS_CLK(clk), .ARST_N(arst_n), .LNK(lnk), .BRK_IRQ(brk_irq),
    .MATCH_A(), .MATCH_B());
  ubc_link_props i_ubc_link_props (.SYS_CLK(clk), .ARST_N(arst_n), .rd_req(lnk.rd_req),
    .rd_long(lnk.rd_long), .rd_ack(lnk.rd_ack), .bc_valid(lnk.bc_valid),
    .bc_fetch(lnk.bc_fetch), .bc_pc(lnk.bc_pc), .bc_next_pc(lnk.bc_next_pc),
    .brk_req(lnk.brk_req), .brk_kind(lnk.brk_kind), .brk_spc(lnk.brk_spc));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // counts break pulses; the cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (brk_irq === 1'b1)
    begin
      hits <= hits + 1;
      spc_seen <= lnk.brk_spc;
    end
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; waits for pready with no assumed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [3:0] idx, input logic [31:0] v);
    apb(1'b1, `HA_CFG_DATA, v);
    apb(1'b1, `HA_CFG_CMD, {28'h0, idx});
  endtask
  // one monitored bus cycle, then the number of breaks it caused
  task automatic bus(input logic [31:0] a, d, input op_size_t s, input logic w, f,
    input logic [31:0] n);
    @(posedge clk);
    hits = 0;
    bcv <= 1'b1;
    bca <= a;
    bcd <= d;
    bcs <= s;
    bcw <= w;
    bcf <= f;
    @(posedge clk);
    bcv <= 1'b0;
    repeat (4) @(posedge clk);
    chk("break count", n, hits);
  endtask
  // one branch event followed by its execution
  task automatic branch(input logic [27:0] ia, ft, dt, pd, input logic irq);
    @(posedge clk);
    tr_v <= 1'b1;
    tr_ia <= ia;
    tr_ft <= ft;
    tr_dt <= dt;
    tr_pd <= pd;
    tr_int <= irq;
    tr_ds <= irq;
    @(posedge clk);
    tr_v <= 1'b0;
    tr_ex <= 1'b1;
    @(posedge clk);
    tr_ex <= 1'b0;
  endtask
  task automatic read_pair(input logic [31:0] es, ed);
    apb(1'b1, `HA_TRACE, 32'h0);
    repeat (6) @(posedge clk);
    apb(1'b0, `HA_SRC, 32'h0);
    chk("trace source", es, rdata);
    apb(1'b0, `HA_DST, 32'h0);
    chk("trace target", ed, rdata);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `HA_STAT, 32'h0);
    chk("status after reset", 32'h0, rdata);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    // channel a is set before data compare is on, so its size stays open
    cfg(`IDX_BAR_A, 32'h1003);
    cfg(`IDX_COND_A, 32'h19);
    cfg(`IDX_CTRL, 32'h20);
    cfg(`IDX_BAR_B, 32'h2000);
    cfg(`IDX_COND_B, 32'hA9);
    cfg(`IDX_DATA_B, 32'hFFFFA512);
    for (int i = 0; i < 8; i++)
    begin
      bus(rows[i].a, rows[i].d, rows[i].s, rows[i].w, 1'b0, rows[i].n);
      if (rows[i].n == 32'h1)
        chk("data saved pc", rows[i].a + 32'h2, spc_seen);
    end
    $display("address and data rows done");
    cfg(`IDX_CTRL, 32'h1);
    cfg(`IDX_COND_B, 32'hD9);
    bus(32'h2000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h0);
    bus(32'h1000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h0);
    bus(32'h2000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h1);
    bus(32'h2000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h0);
    cfg(`IDX_BAR_B, 32'h1000);
    bus(32'h1000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h0);
    cfg(`IDX_BAR_B, 32'h2000);
    cfg(`IDX_EXEC_CNT, 32'h1);
    cfg(`IDX_CTRL, 32'h5);
    bus(32'h1000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h0);
    bus(32'h2000, 32'h0, SZ_LONG, 1'b0, 1'b0, 32'h1);
    $display("sequence tests done");
    cfg(`IDX_CTRL, 32'h0);
    cfg(`IDX_BAR_A, 32'h3000);
    cfg(`IDX_COND_A, 32'h15);
    bus(32'h3000, 32'h0, SZ_WORD, 1'b0, 1'b1, 32'h1);
    chk("pre fetch saved pc", 32'h3000, spc_seen);
    cfg(`IDX_CTRL, 32'h8);
    bus(32'h3000, 32'h0, SZ_WORD, 1'b0, 1'b1, 32'h1);
    chk("post fetch saved pc", 32'h3002, spc_seen);
    $display("saved pc tests done");
    cfg(`IDX_CTRL, 32'h2);
    branch(28'h100, 28'h104, 28'h200, 28'h0, 1'b0);
    // one unread pair, and its branch already executed, so the trace pointer is back at zero
    apb(1'b1, `HA_TRACE, 32'h1);
    repeat (4) @(posedge clk);
    apb(1'b0, `HA_SRC, 32'h0);
    chk("trace pointers", 32'h100, rdata);
    read_pair(32'hA0000104, 32'h80000200);
    read_pair(32'h0, 32'h0);
    branch(28'h300, 28'h304, 28'h400, 28'h302, 1'b1);
    read_pair(32'hF0000302, 32'h80000400);
    $display("trace tests done");
    tally_and_finish();
  end
endmodule
